//--- burst4_cfg.svh
/*
  constants for the burst-of-four synchronous sram port and its controller.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef BURST4_CFG_SVH
`define BURST4_CFG_SVH

// ----------------------------------------
// burst shape
// ----------------------------------------
`define BURST_LEN 4
`define BURST_CNT_W 2
`define NARROW_START 2'h0

// ----------------------------------------
// lanes and address widths per data width
// ----------------------------------------
`define NIBBLE_W 4
`define BYTE_LANE_W 9
`define AW_NARROW 20
`define AW_X18 21
`define AW_X36 20

// ----------------------------------------
// timing: input clock pair is ref_clk / 2
// ----------------------------------------
`define REF_CLK_NS 8
`define K_PERIOD_CYC 2
`define MAX_INFLIGHT_RD 3'h2

`endif

//--- burst4_pkg.sv
/*
  types and width helpers shared by both ends of the sram link.
  assumes burst4_cfg.svh is on the include path.
*/
`include "burst4_cfg.svh"
`default_nettype none

package burst4_pkg;

    // ----------------------------------------
    // access direction as seen on the link
    // ----------------------------------------
    typedef enum logic {
        ACC_WRITE = 1'h0,
        ACC_READ = 1'h1
    } access_t;

    // ----------------------------------------
    // write engine states of the device
    // ----------------------------------------
    typedef enum logic [2:0] {
        WS_IDLE = 3'h1,
        WS_LOW = 3'h2,
        WS_HIGH = 3'h4
    } wr_state_t;

    function automatic int addr_w_of(input int dw);
        return (dw == 18) ? `AW_X18 : ((dw == 36) ? `AW_X36 : `AW_NARROW);
    endfunction : addr_w_of

    function automatic int sel_w_of(input int dw);
        return (dw == 8) ? 2 : dw / `BYTE_LANE_W;
    endfunction : sel_w_of

    function automatic int lane_w_of(input int dw);
        return (dw == 8) ? `NIBBLE_W : `BYTE_LANE_W;
    endfunction : lane_w_of

    function automatic int int_aw_of(input int dw);
        return (dw <= 9) ? addr_w_of(dw) + `BURST_CNT_W : addr_w_of(dw);
    endfunction : int_aw_of

endpackage : burst4_pkg

`default_nettype wire

//--- sram_link_if.sv
/*
  the link between the memory controller and the sram port.
  assumes both ends run on one ref_clk; clock edges travel as strobes.
*/
`timescale 1ns/1ps
`default_nettype none

interface sram_link_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20,
    parameter int SEL_W = 4
) ();
    // edge strobes of the input pair (k) and output pair (c)
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    logic c_present;
    // command
    logic transaction_load_n;
    logic read_not_write;
    logic [ADDR_W-1:0] addr;
    // lane selects: bit0 low_half / lane0, bit1 high_half / lane1, ...
    logic [SEL_W-1:0] write_sel_n;
    // shared data pins, resolved from the enables
    logic [DATA_W-1:0] dq_ctl_out;
    logic dq_ctl_oe;
    logic [DATA_W-1:0] dq_dev_out;
    logic dq_dev_oe;
    logic [DATA_W-1:0] dq;

    assign dq = dq_dev_oe ? dq_dev_out : (dq_ctl_oe ? dq_ctl_out : '0);

    modport dev (
        input k_rise, kn_rise, c_rise, cn_rise, c_present,
        input transaction_load_n, read_not_write, addr, write_sel_n, dq,
        output dq_dev_out, dq_dev_oe
    );

    modport ctl (
        output k_rise, kn_rise, c_rise, cn_rise, c_present,
        output transaction_load_n, read_not_write, addr, write_sel_n,
        output dq_ctl_out, dq_ctl_oe,
        input dq
    );
endinterface : sram_link_if

`default_nettype wire

//--- burst4_sram_device.sv
/*
  the sram end: command latch, burst counter, lane-masked writes and
  double-rate read launch. assumes the controller keeps bursts apart.
*/
`timescale 1ns/1ps
`default_nettype none
`include "burst4_cfg.svh"

module burst4_sram_device #(
    parameter int DATA_W = 36,
    parameter int MEM_AW = burst4_pkg::int_aw_of(DATA_W)
) (
    // link to the controller
    sram_link_if.dev link,
    // local status
    output logic read_driving,
    output logic write_beat,
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn
);
    localparam int SEL_W = burst4_pkg::sel_w_of(DATA_W);
    localparam int LANE_W = burst4_pkg::lane_w_of(DATA_W);
    localparam int IAW = burst4_pkg::int_aw_of(DATA_W);
    localparam int UW = IAW - `BURST_CNT_W;
    localparam bit NARROW = (DATA_W <= 9);

    generate
        if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36))
            $error("DATA_W must be 8, 9, 18 or 36");
        if (MEM_AW < 1 || MEM_AW > IAW)
            $error("MEM_AW must lie between 1 and the internal address width");
        if (SEL_W * LANE_W != DATA_W)
            $error("lane layout does not cover the data width");
    endgenerate

    // ----------------------------------------
    // storage array and burst address helper
    // ----------------------------------------
    logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

    function automatic logic [MEM_AW-1:0] word_addr(
        input logic [UW-1:0] upper,
        input logic [1:0] start,
        input logic [1:0] beat
    );
        logic [IAW-1:0] full;
        full = {upper, 2'(start + beat)};
        return full[MEM_AW-1:0];
    endfunction : word_addr

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic load_rd, load_wr;
    logic [UW-1:0] ld_upper;
    logic [1:0] ld_start;

    always_comb
    begin
        load_rd = link.k_rise && !link.transaction_load_n && link.read_not_write;
        load_wr = link.k_rise && !link.transaction_load_n && !link.read_not_write;
        if (NARROW)
        begin
            ld_upper = UW'(link.addr);
            ld_start = `NARROW_START;
        end
        else
        begin
            ld_upper = UW'(link.addr >> `BURST_CNT_W);
            ld_start = link.addr[1:0];
        end
    end

    // ----------------------------------------
    // pending read and write, latched on k
    // ----------------------------------------
    logic rd_pend, wr_pend, rd_take, wr_take;
    logic [UW-1:0] rd_pend_upper;
    logic [1:0] rd_pend_start;
    logic [UW-1:0] wr_pend_upper;
    logic [1:0] wr_pend_start;

    // address and direction only land when a load is seen on k
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_pend_upper <= '0;
            rd_pend_start <= 2'h0;
            wr_pend_upper <= '0;
            wr_pend_start <= 2'h0;
        end
        else if (load_rd)
        begin
            rd_pend_upper <= ld_upper;
            rd_pend_start <= ld_start;
        end
        else if (load_wr)
        begin
            wr_pend_upper <= ld_upper;
            wr_pend_start <= ld_start;
        end
    end

    // a new load wins over the clear by the engine that takes it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_pend <= 1'h0;
            wr_pend <= 1'h0;
        end
        else
        begin
            rd_pend <= load_rd || (rd_pend && !rd_take);
            wr_pend <= load_wr || (wr_pend && !wr_take);
        end
    end

    // ----------------------------------------
    // write engine: words 0,1 then 2,3
    // ----------------------------------------
    burst4_pkg::wr_state_t wr_state;
    logic [UW-1:0] wr_upper;
    logic [1:0] wr_start;
    logic wr_en;
    logic [1:0] wr_beat;
    logic [MEM_AW-1:0] wr_addr;

    always_comb
    begin
        wr_en = 1'h0;
        wr_beat = 2'h0;
        wr_take = 1'h0;
        wr_addr = word_addr(wr_upper, wr_start, 2'h0);
        if (link.k_rise)
        begin
            if (wr_state == burst4_pkg::WS_LOW)
            begin
                wr_en = 1'h1;
                wr_beat = 2'h2;
                wr_addr = word_addr(wr_upper, wr_start, 2'h2);
            end
            else if (wr_pend)
            begin
                wr_en = 1'h1;
                wr_take = 1'h1;
                wr_addr = word_addr(wr_pend_upper, wr_pend_start, 2'h0);
            end
        end
        else if (link.kn_rise && wr_state != burst4_pkg::WS_IDLE)
        begin
            wr_en = 1'h1;
            wr_beat = (wr_state == burst4_pkg::WS_LOW) ? 2'h1 : 2'h3;
            wr_addr = word_addr(wr_upper, wr_start, wr_beat);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_state <= burst4_pkg::WS_IDLE;
            wr_upper <= '0;
            wr_start <= 2'h0;
        end
        else if (link.k_rise)
        begin
            case (wr_state)
                burst4_pkg::WS_LOW: wr_state <= burst4_pkg::WS_HIGH;
                default:
                begin
                    if (wr_pend)
                    begin
                        wr_state <= burst4_pkg::WS_LOW;
                        wr_upper <= wr_pend_upper;
                        wr_start <= wr_pend_start;
                    end
                    else
                    begin
                        wr_state <= burst4_pkg::WS_IDLE;
                    end
                end
            endcase
        end
    end

    // selects are taken on the same edge as the word they qualify
    always_ff @(posedge ref_clk)
    begin
        for (int l = 0; l < SEL_W; l++)
        begin
            if (wr_en && !link.write_sel_n[l])
                mem[wr_addr][l*LANE_W +: LANE_W] <= link.dq[l*LANE_W +: LANE_W];
        end
    end

    // ----------------------------------------
    // read engine: launch on output edges
    // ----------------------------------------
    logic out_pos, out_neg, rd_act;
    logic [1:0] rd_beat;
    logic [UW-1:0] rd_upper;
    logic [1:0] rd_start;

    always_comb
    begin
        out_pos = link.c_present ? link.c_rise : link.k_rise;
        out_neg = link.c_present ? link.cn_rise : link.kn_rise;
        rd_take = out_neg && rd_pend && !(rd_act && rd_beat != 2'h3);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_act <= 1'h0;
            rd_beat <= 2'h0;
            rd_upper <= '0;
            rd_start <= 2'h0;
            link.dq_dev_out <= '0;
            link.dq_dev_oe <= 1'h0;
        end
        else if (out_pos || out_neg)
        begin
            if (rd_act && rd_beat != 2'h3)
            begin
                rd_beat <= 2'(rd_beat + 2'h1);
                link.dq_dev_out <= mem[word_addr(rd_upper, rd_start, 2'(rd_beat + 2'h1))];
            end
            else if (rd_take)
            begin
                rd_act <= 1'h1;
                rd_beat <= 2'h0;
                rd_upper <= rd_pend_upper;
                rd_start <= rd_pend_start;
                link.dq_dev_out <= mem[word_addr(rd_pend_upper, rd_pend_start, 2'h0)];
                link.dq_dev_oe <= 1'h1;
            end
            else if (out_neg)
            begin
                rd_act <= 1'h0;
                link.dq_dev_oe <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // local status
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            read_driving <= 1'h0;
            write_beat <= 1'h0;
        end
        else
        begin
            read_driving <= link.dq_dev_oe;
            write_beat <= wr_en;
        end
    end

endmodule : burst4_sram_device

`default_nettype wire

//--- burst4_sram_ctl.sv
/*
  the memory controller end: derives the k and c strobes, issues one burst
  every second k period at most, and returns read bursts through a
  two-entry buffer. assumes the device answers with the fixed latency.
*/
`timescale 1ns/1ps
`default_nettype none
`include "burst4_cfg.svh"

module burst4_sram_ctl #(
    parameter int DATA_W = 36
) (
    // link to the device
    sram_link_if.ctl link,
    // mode
    input wire logic use_out_clock,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [burst4_pkg::addr_w_of(DATA_W)-1:0] cmd_addr,
    input wire logic [`BURST_LEN*DATA_W-1:0] cmd_wdata,
    input wire logic [`BURST_LEN*burst4_pkg::sel_w_of(DATA_W)-1:0] cmd_wsel_n,
    // read response, word 0 in the low bits
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [`BURST_LEN*DATA_W-1:0] rsp_data,
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn
);
    localparam int ADDR_W = burst4_pkg::addr_w_of(DATA_W);
    localparam int SEL_W = burst4_pkg::sel_w_of(DATA_W);

    generate
        if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36))
            $error("DATA_W must be 8, 9, 18 or 36");
    endgenerate

    // ----------------------------------------
    // strobe divider and period tracking
    // ----------------------------------------
    logic ph;
    logic launch;
    logic accept;
    logic ld_q;
    logic d1;
    logic d2;

    assign launch = !ph;
    assign accept = cmd_valid && cmd_ready;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ph <= 1'h0;
            link.k_rise <= 1'h0;
            link.kn_rise <= 1'h0;
            link.c_rise <= 1'h0;
            link.cn_rise <= 1'h0;
            link.c_present <= 1'h0;
        end
        else
        begin
            ph <= !ph;
            link.k_rise <= !ph;
            link.kn_rise <= ph;
            link.c_rise <= !ph;
            link.cn_rise <= ph;
            link.c_present <= use_out_clock;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ld_q <= 1'h0;
            d1 <= 1'h0;
            d2 <= 1'h0;
        end
        else if (launch)
        begin
            ld_q <= accept;
            d1 <= ld_q;
            d2 <= d1;
        end
    end

    // ----------------------------------------
    // issued and active burst records
    // ----------------------------------------
    logic iss_rd;
    logic [`BURST_LEN*DATA_W-1:0] iss_data;
    logic [`BURST_LEN*SEL_W-1:0] iss_sel;
    logic act_rd;
    logic [`BURST_LEN*DATA_W-1:0] act_data;
    logic [`BURST_LEN*SEL_W-1:0] act_sel;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            iss_rd <= 1'h0;
            iss_data <= '0;
            iss_sel <= '1;
            act_rd <= 1'h0;
            act_data <= '0;
            act_sel <= '1;
        end
        else
        begin
            if (accept)
            begin
                iss_rd <= cmd_read;
                iss_data <= cmd_wdata;
                iss_sel <= cmd_wsel_n;
            end
            if (launch && ld_q)
            begin
                act_rd <= iss_rd;
                act_data <= iss_data;
                act_sel <= iss_sel;
            end
        end
    end

    // ----------------------------------------
    // command and write data onto the link
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            link.transaction_load_n <= 1'h1;
            link.read_not_write <= 1'h1;
            link.addr <= '0;
        end
        else
        begin
            link.transaction_load_n <= !(launch && accept);
            if (launch && accept)
            begin
                link.read_not_write <= cmd_read;
                link.addr <= cmd_addr;
            end
        end
    end

    // words and their selects change together, one per k or kn edge
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            link.dq_ctl_out <= '0;
            link.dq_ctl_oe <= 1'h0;
            link.write_sel_n <= '1;
        end
        else if (launch)
        begin
            if (ld_q)
            begin
                link.dq_ctl_out <= iss_data[0 +: DATA_W];
                link.write_sel_n <= iss_sel[0 +: SEL_W];
                link.dq_ctl_oe <= !iss_rd;
            end
            else if (d1)
            begin
                link.dq_ctl_out <= act_data[2*DATA_W +: DATA_W];
                link.write_sel_n <= act_sel[2*SEL_W +: SEL_W];
                link.dq_ctl_oe <= !act_rd;
            end
            else
            begin
                link.dq_ctl_oe <= 1'h0;
                link.write_sel_n <= '1;
            end
        end
        else if (d1)
        begin
            link.dq_ctl_out <= act_data[DATA_W +: DATA_W];
            link.write_sel_n <= act_sel[SEL_W +: SEL_W];
        end
        else if (d2)
        begin
            link.dq_ctl_out <= act_data[3*DATA_W +: DATA_W];
            link.write_sel_n <= act_sel[3*SEL_W +: SEL_W];
        end
    end

    // ----------------------------------------
    // read capture and two-entry buffer
    // ----------------------------------------
    logic cap;
    logic [1:0] cap_idx;
    logic push;
    logic pop;
    logic [`BURST_LEN*DATA_W-1:0] push_data;
    logic [3*DATA_W-1:0] rbuf;
    logic [`BURST_LEN*DATA_W-1:0] tail;
    logic tail_v;
    logic [1:0] rd_out;
    logic [1:0] occ;

    always_comb
    begin
        cap = act_rd && (d1 || d2) && (link.k_rise || link.kn_rise);
        cap_idx = {d2, link.kn_rise};
        push = cap && (cap_idx == 2'h3);
        push_data = {link.dq, rbuf};
        pop = rsp_valid && rsp_ready;
        occ = {1'h0, rsp_valid} + {1'h0, tail_v};
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rbuf <= '0;
        else if (cap && !push)
            rbuf[cap_idx*DATA_W +: DATA_W] <= link.dq;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_valid <= 1'h0;
            rsp_data <= '0;
            tail_v <= 1'h0;
            tail <= '0;
        end
        else if (pop)
        begin
            if (tail_v)
            begin
                rsp_data <= tail;
                tail_v <= push;
                tail <= push_data;
            end
            else
            begin
                rsp_valid <= push;
                rsp_data <= push_data;
            end
        end
        else if (push)
        begin
            if (!rsp_valid)
            begin
                rsp_valid <= 1'h1;
                rsp_data <= push_data;
            end
            else
            begin
                tail_v <= 1'h1;
                tail <= push_data;
            end
        end
    end

    // reads in flight plus buffered bursts never exceed the buffer
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_out <= 2'h0;
            cmd_ready <= 1'h0;
        end
        else
        begin
            rd_out <= 2'(rd_out + {1'h0, accept && cmd_read} - {1'h0, push});
            cmd_ready <= ph && !ld_q && ((3'(rd_out) + 3'(occ)) < `MAX_INFLIGHT_RD);
        end
    end

endmodule : burst4_sram_ctl

`default_nettype wire

//--- burst4_link_monitor.sv
/*
  concurrent checks on the sram link between controller and device.
  assumes one ref_clk domain and an asynchronous active-low rstn.
*/
`timescale 1ns/1ps
`default_nettype none

module burst4_link_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // edge strobes
    input wire logic k_rise,
    input wire logic kn_rise,
    input wire logic c_rise,
    input wire logic cn_rise,
    input wire logic c_present,
    // command and pin enables
    input wire logic transaction_load_n,
    input wire logic read_not_write,
    input wire logic dq_ctl_oe,
    input wire logic dq_dev_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // --------------------------------
    // load history, bit i = load i+1 cycles ago
    // --------------------------------
    logic [4:0] rd_hist;
    logic [4:0] wr_hist;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_hist <= '0;
            wr_hist <= '0;
        end
        else
        begin
            rd_hist <= {rd_hist[3:0], !transaction_load_n && read_not_write};
            wr_hist <= {wr_hist[3:0], !transaction_load_n && !read_not_write};
        end
    end

    // --------------------------------
    // assertions
    // --------------------------------
    AST_LOAD_ON_K: assert property (!transaction_load_n |-> k_rise)
        else $error("load outside a positive k cycle");
    AST_K_ALTERNATE: assert property (k_rise |=> kn_rise && !k_rise)
        else $error("negative k strobe does not follow positive one");
    AST_LOAD_SPACING: assert property (!transaction_load_n |=> transaction_load_n [*3])
        else $error("loads closer than two k periods");
    AST_WRITE_BURST: assert property (!transaction_load_n && !read_not_write |=> ##1 dq_ctl_oe [*4])
        else $error("write burst not four words");
    AST_READ_BURST: assert property (!transaction_load_n && read_not_write |=> ##1 dq_dev_oe [*4])
        else $error("read burst not four words");
    AST_READ_WINDOW: assert property (dq_dev_oe |-> |rd_hist[4:1])
        else $error("device drives pins without a read");
    AST_WRITE_WINDOW: assert property (dq_ctl_oe |-> |wr_hist[4:1])
        else $error("controller drives pins without a write");
    AST_NO_CONTENTION: assert property (!(dq_dev_oe && dq_ctl_oe))
        else $error("both ends drive the data pins");
    AST_C_MATCH: assert property (c_present |-> c_rise == k_rise && cn_rise == kn_rise)
        else $error("output clock strobes off the input pair");

    COV_WRITE: cover property (!transaction_load_n && !read_not_write);
    COV_READ_C: cover property (!transaction_load_n && read_not_write && c_present);
    COV_READ_K: cover property (!transaction_load_n && read_not_write && !c_present);
endmodule : burst4_link_monitor

`default_nettype wire

//--- burst4_sram_port_tb_top.sv
/*
  self-checking bench: controller and device joined by the link, x36.
  assumes the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module burst4_sram_port_tb_top;
    logic ref_clk = 1'h0;
    logic rstn, use_out_clock, cmd_valid, cmd_ready, cmd_read;
    logic read_driving, write_beat;
    logic rsp_valid, rsp_ready, stall, rr;
    logic [19:0] cmd_addr, ra;
    logic [143:0] cmd_wdata, rsp_data;
    logic [15:0] cmd_wsel_n;
    logic [35:0] ref_mem [256];
    logic [143:0] q [$];
    int failures = 0;
    int total_checks = 0;
    int beats = 0, drv = 0, wr_bursts = 0, rd_bursts = 0;

    sram_link_if #(.DATA_W(36)) link ();
    burst4_sram_device #(.DATA_W(36), .MEM_AW(8)) burst4_sram_device_i (.link(link),
        .read_driving(read_driving), .write_beat(write_beat), .ref_clk(ref_clk), .rstn(rstn));
    burst4_sram_ctl #(.DATA_W(36)) burst4_sram_ctl_i (.link(link),
        .use_out_clock(use_out_clock), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_wsel_n(cmd_wsel_n), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .ref_clk(ref_clk), .rstn(rstn));
    burst4_link_monitor burst4_link_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
        .k_rise(link.k_rise), .kn_rise(link.kn_rise), .c_rise(link.c_rise),
        .cn_rise(link.cn_rise), .c_present(link.c_present),
        .transaction_load_n(link.transaction_load_n), .read_not_write(link.read_not_write),
        .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe));

    always #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) rsp_ready <= stall ? ($urandom_range(0, 2) == 0) : 1'h1;

    // words written and read cycles driven, for the burst length checks
    always @(posedge ref_clk)
    begin
        if (rstn && write_beat === 1'h1) beats++;
        if (rstn && read_driving === 1'h1) drv++;
    end

    task check(input logic [143:0] seen, input logic [143:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: burst %h expected %h", $time, seen, exp);
        end
    endtask : check

    // send one burst and note its effect on the reference memory
    task issue(input logic rd, input logic [19:0] a, input logic full);
        logic [143:0] exp;
        logic [7:0] idx;
        int n, i, l;
        @(negedge ref_clk);
        cmd_valid = 1'h1;
        cmd_read = rd;
        cmd_addr = a;
        for (i = 0; i < 4; i++) cmd_wdata[i*36+:36] = 36'({$urandom, $urandom});
        cmd_wsel_n = full ? 16'h0 : 16'($urandom);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (cmd_ready !== 1'h1 && n < 100);
        if (n >= 100) failures++;
        for (i = 0; i < 4; i++)
        begin
            idx = {a[7:2], a[1:0] + 2'(i)};
            exp[i*36+:36] = ref_mem[idx];
            for (l = 0; l < 4; l++)
                if (!rd && !cmd_wsel_n[i*4+l]) ref_mem[idx][l*9+:9] = cmd_wdata[i*36+l*9+:9];
        end
        if (rd)
        begin
            q.push_back(exp);
            rd_bursts++;
        end
        else wr_bursts++;
    endtask : issue

    task finish_test(input string name);
        int n;
        @(negedge ref_clk);
        cmd_valid = 1'h0;
        n = 0;
        while (q.size() != 0 && n < 500)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (q.size() != 0) failures++;
        // let the last write land before the next test reads or changes mode
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        check(144'(beats), 144'(4 * wr_bursts));
        check(144'(drv), 144'(4 * rd_bursts));
        $display("test %s done", name);
    endtask : finish_test

    task summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    always @(posedge ref_clk)
        if (rstn && rsp_valid === 1'h1 && rsp_ready === 1'h1)
            check(rsp_data, (q.size() != 0) ? q.pop_front() : 'x);

    initial
    begin
        #160000;
        failures++;
        summarize();
    end

    initial
    begin
        rstn = 0;
        cmd_valid = 0;
        cmd_read = 0;
        cmd_addr = 0;
        cmd_wdata = 0;
        cmd_wsel_n = '1;
        use_out_clock = 1;
        stall = 0;
        void'($urandom(43987));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1;
        // upper address bits vary but the array keeps only the low ones
        for (int k = 0; k < 64; k++) issue(1'h0, {12'($urandom), 6'(k), 2'h0}, 1'h1);
        finish_test("fill");
        repeat (40) issue(1'h0, 20'($urandom), 1'h0);
        finish_test("masked writes");
        stall = 1;
        repeat (40) issue(1'h1, 20'($urandom), 1'h0);
        finish_test("reads on output clock");
        use_out_clock = 0;
        // writes and reads kept in separate halves of the array
        repeat (40)
        begin
            rr = 1'($urandom);
            ra = 20'($urandom);
            ra[7] = rr;
            issue(rr, ra, 1'h0);
        end
        finish_test("mixed in single clock mode");
        summarize();
    end
endmodule : burst4_sram_port_tb_top

`default_nettype wire
